// ---- bench/skf_far_model.sv ----
// Producer and consumer standing on both stream sides
`timescale 1ns/1ns
module skf_far_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_ready,
   input wire logic nearly_full,
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   input wire logic obey_stop,
   input wire logic pop_en,
   input wire logic slow,
   input wire logic [31:0] send_n,
   output logic push,
   output logic [7:0] in_data,
   output logic pop,
   output int sent,
   output int popped,
   output int mism,
   output logic [7:0] last_word,
   output logic took
);
   logic [7:0] q[$];
   logic tick;
   ////////////////////////////////////////////////////////////
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         push <= 1'h0;
         in_data <= 8'h00;
         pop <= 1'h0;
         tick <= 1'h0;
         took <= 1'h0;
         last_word <= 8'h00;
         sent = 0;
         popped = 0;
         mism = 0;
      end else begin
         if (push && in_ready) q.push_back(in_data);
         took <= pop && out_valid;
         if (pop && out_valid) begin
            if (q.size() == 0 || out_data !== q[0]) mism++;
            if (q.size() != 0) last_word <= q[0];
            if (q.size() != 0) q.delete(0);
            popped++;
         end
         tick <= ~tick;
         pop <= pop_en && (!slow || tick);
         if (sent < send_n && !(obey_stop && nearly_full)) begin
            push <= 1'h1;
            in_data <= 8'(sent * 37 + 5);
            sent++;
         end else begin
            push <= 1'h0;
            in_data <= ~in_data;
         end
      end
   end
endmodule

// ---- bench/skf_top_asserts.sv ----
// Concurrent checks on the skid-buffered FIFO ports
`timescale 1ns/1ns
module skf_top_asserts import skf_pkg::*; #(
   parameter int DATA_WIDTH = 8,
   parameter int FIFO_DEPTH = 8,
   localparam int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic push,
   input wire logic [DATA_WIDTH-1:0] in_data,
   input wire logic in_ready,
   input wire logic nearly_full,
   input wire logic pop,
   input wire logic out_valid,
   input wire logic [DATA_WIDTH-1:0] out_data,
   input wire logic [LVL_W-1:0] fill_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic pop_acc;
   logic flush_q;
   assign pop_acc = pop && out_valid;
   // Flush cycle follows a write of the flush bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= psel && penable && pwrite && pready && (paddr == SKF_OFF_CTRL) && pwdata[SKF_CTRL_FLUSH_BIT];
      end
   end
   ////////////////////////////////////////////////////////////
   property p_stop_late; $rose(nearly_full) |-> $past(fill_level) >= 5; endproperty
   a_stop_late: assert property (p_stop_late) else $error("stop rose below threshold");
   property p_ready_full; !in_ready |-> fill_level >= FIFO_DEPTH; endproperty
   a_ready_full: assert property (p_ready_full) else $error("ready low while not full");
   property p_first_word;
      push && in_ready && fill_level == 0 && !flush_q |=> !out_valid ##1 !out_valid ##1 out_valid;
   endproperty
   a_first_word: assert property (p_first_word) else $error("first word not out after two stages");
   property p_drop_full; push && !in_ready && !pop_acc && !flush_q |=> fill_level == $past(fill_level); endproperty
   a_drop_full: assert property (p_drop_full) else $error("push into full buffer changed level");
   property p_push_count;
      push && in_ready && !pop_acc && !flush_q |=> fill_level == $past(fill_level) + 1;
   endproperty
   a_push_count: assert property (p_push_count) else $error("level not raised by push");
   property p_last_pop; pop_acc && !push && fill_level == 1 |=> !out_valid && fill_level == 0; endproperty
   a_last_pop: assert property (p_last_pop) else $error("last pop left word behind");
   property p_hold_word; out_valid && !pop && !flush_q |=> out_valid && $stable(out_data); endproperty
   a_hold_word: assert property (p_hold_word) else $error("presented word changed without pop");
   property p_reset_clear; $rose(presetn) |-> !out_valid && in_ready && !nearly_full && fill_level == 0; endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("stages not vacant after reset");
   property p_apb_answer; psel && !penable |=> pready ##1 !pready; endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("access cycle answer wrong");
   c_stop: cover property ($rose(nearly_full));
   c_drop: cover property (push && !in_ready);
   c_both: cover property (pop_acc && push && in_ready);
endmodule
bind skf_top skf_top_asserts #(.DATA_WIDTH(DATA_WIDTH), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .push(push), .in_data(in_data),
   .in_ready(in_ready), .nearly_full(nearly_full), .pop(pop), .out_valid(out_valid), .out_data(out_data),
   .fill_level(fill_level));

// ---- bench/skf_top_tb_top.sv ----
// Testbench for the skid-buffered FIFO
`timescale 1ns/1ns
module skf_top_tb_top import skf_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, send_n;
   logic push, pop, in_ready, nearly_full, out_valid, obey, pop_en, slow, took;
   logic [7:0] in_data, out_data, nrm_data, last_word;
   logic [3:0] fill_level;
   int sent, popped, mism, bad_count, comparisons;
   skf_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .push(push), .in_data(in_data),
      .in_ready(in_ready), .nearly_full(nearly_full), .pop(pop), .out_valid(out_valid), .out_data(out_data),
      .fill_level(fill_level));
   skf_far_model far (.pclk(pclk), .presetn(presetn), .in_ready(in_ready), .nearly_full(nearly_full),
      .out_valid(out_valid), .out_data(out_data), .obey_stop(obey), .pop_en(pop_en), .slow(slow),
      .send_n(send_n), .push(push), .in_data(in_data), .pop(pop), .sent(sent), .popped(popped), .mism(mism),
      .last_word(last_word), .took(took));
   // Normal-mode copy: out_data shows the word taken by the last pop
   skf_top #(.SHOWAHEAD(1'b0)) uut_nrm (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .push(push),
      .in_data(in_data), .in_ready(), .nearly_full(), .pop(pop), .out_valid(), .out_data(nrm_data),
      .fill_level());
   always @(posedge pclk) begin
      if (presetn && took) begin
         check({24'h0, nrm_data}, {24'h0, last_word});
      end
   end
   ////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Whole run is under a thousand cycles; allow twenty thousand
   initial begin
      #200000;
      bad_count++;
      wrap_up;
   end
   initial begin
      presetn = 1'h0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {obey, pop_en, slow, send_n} = {3'h4, 32'h0};
      {bad_count, comparisons} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      xfer(1'h0, SKF_OFF_THRESH, 32'h0);
      check(rd, 32'h5);
      xfer(1'h0, SKF_OFF_STATUS, 32'h0);
      check(rd, 32'h3100);
      xfer(1'h0, 12'h010, 32'h0);
      check({31'h0, err}, 32'h1);
      xfer(1'h1, SKF_OFF_THRESH, 32'h7);
      xfer(1'h0, SKF_OFF_THRESH, 32'h0);
      check(rd, 32'h7);
      // Producer outruns a half-rate consumer
      pop_en <= 1'h1;
      slow <= 1'h1;
      send_n <= 32'd40;
      while (popped != 40) @(posedge pclk);
      check(mism, 0);
      xfer(1'h0, SKF_OFF_DROPS, 32'h0);
      check(rd, 32'h0);
      // Consumer stopped, producer ignores the stop
      pop_en <= 1'h0;
      obey <= 1'h0;
      send_n <= 32'd52;
      while (sent != 52) @(posedge pclk);
      xfer(1'h0, SKF_OFF_DROPS, 32'h0);
      check(rd, 32'h2);
      xfer(1'h0, SKF_OFF_STATUS, 32'h0);
      check(rd, 32'h0e0a);
      // Drain at full rate
      slow <= 1'h0;
      pop_en <= 1'h1;
      while (popped != 50) @(posedge pclk);
      check(mism, 0);
      xfer(1'h1, SKF_OFF_DROPS, 32'h0);
      xfer(1'h1, SKF_OFF_STATUS, 32'hffff);
      xfer(1'h0, SKF_OFF_DROPS, 32'h0);
      check(rd, 32'h0);
      xfer(1'h0, SKF_OFF_STATUS, 32'h0);
      check(rd, 32'h3100);
      // Flush with words parked inside
      pop_en <= 1'h0;
      obey <= 1'h1;
      send_n <= 32'd55;
      while (sent != 55) @(posedge pclk);
      xfer(1'h1, SKF_OFF_CTRL, 32'h1);
      xfer(1'h0, SKF_OFF_STATUS, 32'h0);
      check(rd, 32'h3100);
      wrap_up;
   end
endmodule

// ---- pkg/skf_pkg.sv ----
// Constants shared by the skid-buffered FIFO and its storage
package skf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int SKF_DEPTH = 8;
   localparam int SKF_WIDTH = 8;
   localparam int SKF_STAGES = 2;
   localparam int SKF_STOP_SLACK = 5;
   localparam int SKF_ADDR_W = 12;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [11:0] SKF_OFF_CTRL = 12'h000;
   localparam logic [11:0] SKF_OFF_THRESH = 12'h004;
   localparam logic [11:0] SKF_OFF_STATUS = 12'h008;
   localparam logic [11:0] SKF_OFF_DROPS = 12'h00c;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SKF_CTRL_FLUSH_BIT = 0;
   localparam int SKF_STAT_LVL_LSB = 0;
   localparam int SKF_STAT_EMPTY_BIT = 8;
   localparam int SKF_STAT_FULL_BIT = 9;
   localparam int SKF_STAT_NEAR_BIT = 10;
   localparam int SKF_STAT_STOP_BIT = 11;
   localparam int SKF_STAT_VAC1_BIT = 12;
   localparam int SKF_STAT_VAC2_BIT = 13;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] SKF_THRESH_RST = 8'h05;
   localparam logic [7:0] SKF_DROPS_RST = 8'h00;
   localparam logic [31:0] SKF_DATA_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      SKF_REG_CTRL,
      SKF_REG_THRESH,
      SKF_REG_STATUS,
      SKF_REG_DROPS,
      SKF_REG_NONE
   } skf_reg_e;

endpackage

// ---- rtl/skf_store.sv ----
// Storage FIFO with registered head word and valid/ready on both sides
`timescale 1ns/1ns
module skf_store import skf_pkg::*; #(
   parameter int WIDTH = SKF_WIDTH,
   parameter int DEPTH = SKF_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic srst,
   input wire logic wr_valid,
   input wire logic [WIDTH-1:0] wr_data,
   output logic wr_ready,
   input wire logic rd_ready,
   output logic rd_valid,
   output logic [WIDTH-1:0] rd_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH) + 1;
   localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] count_r, count_nxt;
   logic ready_r, ready_nxt, valid_r, valid_nxt;
   logic [WIDTH-1:0] head_r, head_nxt;
   logic wr_take, rd_take;

   function automatic logic [AW-1:0] skf_wrap_inc(input logic [AW-1:0] p);
      skf_wrap_inc = (p == LAST_C) ? '0 : p + 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      wr_take = wr_valid && ready_r && !srst;
      rd_take = rd_ready && valid_r && !srst;
      wr_ptr_nxt = wr_take ? skf_wrap_inc(wr_ptr_r) : wr_ptr_r;
      rd_ptr_nxt = rd_take ? skf_wrap_inc(rd_ptr_r) : rd_ptr_r;
      count_nxt = count_r + CW'(wr_take) - CW'(rd_take);
      if (srst) begin
         wr_ptr_nxt = '0;
         rd_ptr_nxt = '0;
         count_nxt = '0;
      end
      ready_nxt = (count_nxt != FULL_C);
      valid_nxt = (count_nxt != '0);
      // Registered head word, bypassing a write into the head slot
      if (wr_take && (wr_ptr_r == rd_ptr_nxt)) begin
         head_nxt = wr_data;
      end else begin
         head_nxt = mem[rd_ptr_nxt];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
         ready_r <= 1'b1;
         valid_r <= 1'b0;
         head_r <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r <= count_nxt;
         ready_r <= ready_nxt;
         valid_r <= valid_nxt;
         head_r <= head_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (wr_take) begin
         mem[wr_ptr_r] <= wr_data;
      end
   end

   assign wr_ready = ready_r;
   assign rd_valid = valid_r;
   assign rd_data = head_r;

endmodule

// ---- rtl/skf_top.sv ----
// Skid-buffered single-clock FIFO with delayed stop and APB status registers
// Function
// - Nearly-full stop passes two register stages before reaching the producer.
// - Threshold is clamped so the delayed-stop words always fit.
// - Read side runs through two cascaded skid output stages.
// - Build option picks look-ahead acknowledge or normal request pop meaning.
// - Fill level width is log2 ceiling of depth plus one.
// - Ready shows buffer not full; valid shows a word at the output.
// - Fill level counts stored words plus each occupied output stage.
// - Reset marks both output stages vacant.
// - Stage two loads when vacant or popped; stage one when vacant or two loads.
// - Storage is read only when not empty and stage one can load.
// - Storage clears synchronously and presents its head through a register.
// - Immediate full and empty flags are acted on in the same cycle.
`timescale 1ns/1ns
module skf_top import skf_pkg::*; #(
   parameter int DATA_WIDTH = SKF_WIDTH,
   parameter int FIFO_DEPTH = SKF_DEPTH,
   parameter bit SHOWAHEAD = 1'b1,
   localparam int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [SKF_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic push,
   input wire logic [DATA_WIDTH-1:0] in_data,
   output logic in_ready,
   output logic nearly_full,
   input wire logic pop,
   output logic out_valid,
   output logic [DATA_WIDTH-1:0] out_data,
   output logic [LVL_W-1:0] fill_level
);

   localparam logic [7:0] SAFE_THRESH = 8'(FIFO_DEPTH + SKF_STAGES - SKF_STOP_SLACK);
   localparam logic [LVL_W-1:0] CAPACITY = LVL_W'(FIFO_DEPTH + SKF_STAGES);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic st_ready, st_valid;
   logic [DATA_WIDTH-1:0] st_data;
   logic pop_take, push_take, ld1, ld2, rd_req;
   logic stage_one_vacant_r, stage_one_vacant_nxt;
   logic stage_two_vacant_r, stage_two_vacant_nxt;
   logic [DATA_WIDTH-1:0] s1_data_r, s1_data_nxt, s2_data_r, s2_data_nxt;
   logic [DATA_WIDTH-1:0] out_data_r, out_data_nxt;
   logic out_valid_r, out_valid_nxt;
   logic [LVL_W-1:0] fill_r, fill_nxt;
   logic near1_r, near1_nxt, near2_r, near2_nxt;
   logic [7:0] thr_eff;
   logic [7:0] thr_r, thr_nxt;
   logic [7:0] drops_r, drops_nxt;
   logic flush_r, flush_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
   logic setup, wr_access;
   skf_reg_e idx;

   function automatic skf_reg_e skf_decode(input logic [SKF_ADDR_W-1:0] a);
      if (a == SKF_OFF_CTRL) begin
         skf_decode = SKF_REG_CTRL;
      end else if (a == SKF_OFF_THRESH) begin
         skf_decode = SKF_REG_THRESH;
      end else if (a == SKF_OFF_STATUS) begin
         skf_decode = SKF_REG_STATUS;
      end else if (a == SKF_OFF_DROPS) begin
         skf_decode = SKF_REG_DROPS;
      end else begin
         skf_decode = SKF_REG_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Storage
   skf_store #(
      .WIDTH(DATA_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_store (
      .clk(pclk),
      .rst_n(presetn),
      .srst(flush_r),
      .wr_valid(push),
      .wr_data(in_data),
      .wr_ready(st_ready),
      .rd_ready(rd_req),
      .rd_valid(st_valid),
      .rd_data(st_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output stages and flow control, next state
   always_comb begin
      pop_take = pop && out_valid_r && !flush_r;
      push_take = push && st_ready && !flush_r;
      ld2 = stage_two_vacant_r || pop_take;
      ld1 = stage_one_vacant_r || ld2;
      rd_req = st_valid && ld1;
      stage_one_vacant_nxt = stage_one_vacant_r;
      stage_two_vacant_nxt = stage_two_vacant_r;
      s1_data_nxt = s1_data_r;
      s2_data_nxt = s2_data_r;
      if (ld1) begin
         stage_one_vacant_nxt = !st_valid;
         s1_data_nxt = st_data;
      end
      if (ld2) begin
         stage_two_vacant_nxt = stage_one_vacant_r;
         s2_data_nxt = s1_data_r;
      end
      fill_nxt = fill_r + LVL_W'(push_take) - LVL_W'(pop_take);
      if (flush_r) begin
         stage_one_vacant_nxt = 1'b1;
         stage_two_vacant_nxt = 1'b1;
         fill_nxt = '0;
      end
      out_valid_nxt = !stage_two_vacant_nxt;
      if (SHOWAHEAD) begin
         out_data_nxt = s2_data_nxt;
      end else if (pop_take) begin
         out_data_nxt = s2_data_r;
      end else begin
         out_data_nxt = out_data_r;
      end
      thr_eff = (thr_r > SAFE_THRESH) ? SAFE_THRESH : thr_r;
      near1_nxt = (8'(fill_nxt) >= thr_eff);
      near2_nxt = near1_r;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stages and flow control, registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_one_vacant_r <= 1'b1;
         stage_two_vacant_r <= 1'b1;
         s1_data_r <= '0;
         s2_data_r <= '0;
         out_data_r <= '0;
         out_valid_r <= 1'b0;
         fill_r <= '0;
         near1_r <= 1'b0;
         near2_r <= 1'b0;
      end else begin
         stage_one_vacant_r <= stage_one_vacant_nxt;
         stage_two_vacant_r <= stage_two_vacant_nxt;
         s1_data_r <= s1_data_nxt;
         s2_data_r <= s2_data_nxt;
         out_data_r <= out_data_nxt;
         out_valid_r <= out_valid_nxt;
         fill_r <= fill_nxt;
         near1_r <= near1_nxt;
         near2_r <= near2_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, next state
   always_comb begin
      idx = skf_decode(paddr);
      setup = psel && !penable;
      wr_access = psel && penable && pwrite && pready_r;
      thr_nxt = thr_r;
      flush_nxt = 1'b0;
      drops_nxt = drops_r;
      if (wr_access && (idx == SKF_REG_CTRL)) begin
         flush_nxt = pwdata[SKF_CTRL_FLUSH_BIT];
      end
      if (wr_access && (idx == SKF_REG_THRESH)) begin
         thr_nxt = pwdata[7:0];
      end
      if (wr_access && (idx == SKF_REG_DROPS)) begin
         drops_nxt = SKF_DROPS_RST;
      end
      // A drop in the clearing cycle still counts
      if (push && !st_ready && !flush_r) begin
         drops_nxt = (drops_nxt == 8'hff) ? drops_nxt : drops_nxt + 8'h01;
      end
      pready_nxt = setup;
      pslverr_nxt = setup && (idx == SKF_REG_NONE);
      prdata_nxt = SKF_DATA_RST;
      if (setup && !pwrite) begin
         if (idx == SKF_REG_THRESH) begin
            prdata_nxt[7:0] = thr_r;
         end else if (idx == SKF_REG_STATUS) begin
            prdata_nxt[SKF_STAT_LVL_LSB +: LVL_W] = fill_r;
            prdata_nxt[SKF_STAT_EMPTY_BIT] = (fill_r == '0);
            prdata_nxt[SKF_STAT_FULL_BIT] = (fill_r == CAPACITY);
            prdata_nxt[SKF_STAT_NEAR_BIT] = near1_r;
            prdata_nxt[SKF_STAT_STOP_BIT] = near2_r;
            prdata_nxt[SKF_STAT_VAC1_BIT] = stage_one_vacant_r;
            prdata_nxt[SKF_STAT_VAC2_BIT] = stage_two_vacant_r;
         end else if (idx == SKF_REG_DROPS) begin
            prdata_nxt[7:0] = drops_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         thr_r <= SKF_THRESH_RST;
         drops_r <= SKF_DROPS_RST;
         flush_r <= 1'b0;
         prdata_r <= SKF_DATA_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         thr_r <= thr_nxt;
         drops_r <= drops_nxt;
         flush_r <= flush_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign in_ready = st_ready;
   assign nearly_full = near2_r;
   assign out_valid = out_valid_r;
   assign out_data = out_data_r;
   assign fill_level = fill_r;

endmodule
